// [sscp_parser.sv]
`timescale 1ns/1ps
module sscp_parser #(
    parameter int CYC_PER_MS = sscp_pkg::SSCP_CYC_PER_TICK
)
(
    input wire logic sys_clk_i,
    input wire logic rst_i,
    input wire logic host_valid_i,
    input wire logic [7:0] host_byte_i,
    input wire logic host_dtr_i,
    input wire logic cfg_load_i,
    input wire logic cfg_four_byte_i,
    input wire logic [7:0] cfg_prefix_first_i,
    input wire logic [7:0] cfg_prefix_second_i,
    input wire logic [7:0] cfg_prefix_third_i,
    input wire logic cfg_dtr_gate_i,
    input wire logic [3:0] cfg_init_tx_mask_i,
    input wire logic [3:0] cfg_init_rx_sel_i,
    output logic host_ready_o,
    output logic slv_valid_o,
    output logic [7:0] slv_byte_o,
    output logic [3:0] slv_mask_o,
    output logic [3:0] rx_sel_o,
    output logic drain_o,
    output logic [3:0] purge_o,
    output logic ign_active_o
);
    sscp_pkg::sscp_state_t state_r, state_nxt;
    logic [7:0] prefix_byte_first_r, prefix_byte_second_r, prefix_byte_third_r;
    logic four_byte_r;
    logic gate_en_r;
    logic [7:0] hold_r [0:sscp_pkg::SSCP_HOLD_DEPTH-1];
    logic [sscp_pkg::SSCP_HOLD_W-1:0] hold_cnt_r, hold_rd_r;
    logic [7:0] op_r;
    logic [3:0] tx_mask_r;
    logic ign_start_r;
    logic [3:0] ign_code_r;
    logic dtr_s;
    logic accept, detect;
    logic is_first, is_second, is_third, is_sel, is_off, is_parm_op, is_digit;
    logic push, fwd, cmd_sel, cmd_off, cmd_send, cmd_clr, cmd_ign;
    logic [7:0] sel_diff;

    // DTR arrives from a pin
    sscp_sync2 u_dtr_sync (
        .sys_clk_i(sys_clk_i),
        .rst_i(rst_i),
        .d_i(host_dtr_i),
        .q_o(dtr_s)
    );

    sscp_ign_timer #(.CYC_PER_MS(CYC_PER_MS)) u_ign_timer (
        .sys_clk_i(sys_clk_i),
        .rst_i(rst_i),
        .start_i(ign_start_r),
        .code_i(ign_code_r),
        .active_o(ign_active_o)
    );

    assign accept = host_valid_i && host_ready_o;
    // Detection off during the timed window or while gated DTR is low
    assign detect = !ign_active_o && !(gate_en_r && !dtr_s);

    // Byte classification
    assign is_first = (host_byte_i == prefix_byte_first_r);
    assign is_second = (host_byte_i == prefix_byte_second_r);
    assign is_third = (host_byte_i == prefix_byte_third_r);
    assign is_sel = (host_byte_i >= sscp_pkg::SSCP_OPC_SEL_A) && (host_byte_i <= sscp_pkg::SSCP_OPC_SEL_D);
    assign is_off = (host_byte_i == sscp_pkg::SSCP_OPC_OFF);
    assign is_parm_op = (host_byte_i == sscp_pkg::SSCP_OPC_SEND) || (host_byte_i == sscp_pkg::SSCP_OPC_CLEAR)
        || (host_byte_i == sscp_pkg::SSCP_OPC_IGNORE);
    assign is_digit = (host_byte_i >= sscp_pkg::SSCP_DIGIT_0) && (host_byte_i <= sscp_pkg::SSCP_DIGIT_9);
    assign sel_diff = host_byte_i - sscp_pkg::SSCP_OPC_SEL_A;

    // Parser decisions for the byte offered this cycle
    always_comb
    begin
        state_nxt = state_r;
        push = 1'b0;
        fwd = 1'b0;
        cmd_sel = 1'b0;
        cmd_off = 1'b0;
        cmd_send = 1'b0;
        cmd_clr = 1'b0;
        cmd_ign = 1'b0;
        case (state_r)
            sscp_pkg::SSCP_ST_IDLE:
            begin
                if (accept && detect && is_first)
                begin
                    push = 1'b1;
                    state_nxt = sscp_pkg::SSCP_ST_P2;
                end
                else if (accept)
                    fwd = 1'b1;
            end
            sscp_pkg::SSCP_ST_P2:
            begin
                if (accept)
                begin
                    push = 1'b1;
                    if (!is_second)
                        state_nxt = sscp_pkg::SSCP_ST_FLUSH;
                    else if (four_byte_r)
                        state_nxt = sscp_pkg::SSCP_ST_P3;
                    else
                        state_nxt = sscp_pkg::SSCP_ST_OPC;
                end
            end
            sscp_pkg::SSCP_ST_P3:
            begin
                if (accept)
                begin
                    push = 1'b1;
                    state_nxt = is_third ? sscp_pkg::SSCP_ST_OPC : sscp_pkg::SSCP_ST_FLUSH;
                end
            end
            sscp_pkg::SSCP_ST_OPC:
            begin
                if (accept)
                begin
                    if (is_sel || is_off)
                    begin
                        cmd_sel = is_sel;
                        cmd_off = is_off;
                        state_nxt = sscp_pkg::SSCP_ST_IDLE;
                    end
                    else
                    begin
                        push = 1'b1;
                        // Unknown opcode falls back to data
                        state_nxt = is_parm_op ? sscp_pkg::SSCP_ST_PARM : sscp_pkg::SSCP_ST_FLUSH;
                    end
                end
            end
            sscp_pkg::SSCP_ST_PARM:
            begin
                if (accept)
                begin
                    if (op_r == sscp_pkg::SSCP_OPC_IGNORE && !is_digit)
                    begin
                        push = 1'b1;
                        state_nxt = sscp_pkg::SSCP_ST_FLUSH;
                    end
                    else
                    begin
                        cmd_send = (op_r == sscp_pkg::SSCP_OPC_SEND);
                        cmd_clr = (op_r == sscp_pkg::SSCP_OPC_CLEAR);
                        cmd_ign = (op_r == sscp_pkg::SSCP_OPC_IGNORE);
                        state_nxt = sscp_pkg::SSCP_ST_IDLE;
                    end
                end
            end
            sscp_pkg::SSCP_ST_FLUSH:
            begin
                if (hold_rd_r == hold_cnt_r - 1'b1)
                    state_nxt = sscp_pkg::SSCP_ST_IDLE;
            end
            default:
                state_nxt = sscp_pkg::SSCP_ST_IDLE;
        endcase
    end

    // State and host back-pressure; ready drops for the whole release
    always_ff @(posedge sys_clk_i)
    begin
        if (rst_i)
        begin
            state_r <= sscp_pkg::SSCP_ST_IDLE;
            host_ready_o <= 1'b0;
        end
        else
        begin
            state_r <= state_nxt;
            host_ready_o <= (state_nxt != sscp_pkg::SSCP_ST_FLUSH);
        end
    end

    // Prefix configuration; reset restores the shipped defaults
    always_ff @(posedge sys_clk_i)
    begin
        if (rst_i)
        begin
            prefix_byte_first_r <= sscp_pkg::SSCP_DEF_FIRST;
            prefix_byte_second_r <= sscp_pkg::SSCP_DEF_SECOND;
            prefix_byte_third_r <= sscp_pkg::SSCP_DEF_THIRD;
            four_byte_r <= sscp_pkg::SSCP_DEF_FOUR_BYTE;
            gate_en_r <= 1'b0;
        end
        else if (cfg_load_i)
        begin
            prefix_byte_first_r <= cfg_prefix_first_i;
            prefix_byte_second_r <= cfg_prefix_second_i;
            prefix_byte_third_r <= cfg_prefix_third_i;
            four_byte_r <= cfg_four_byte_i;
            gate_en_r <= cfg_dtr_gate_i;
        end
    end

    // Holding buffer; emptied whenever the parser returns to idle
    always_ff @(posedge sys_clk_i)
    begin
        if (rst_i || state_nxt == sscp_pkg::SSCP_ST_IDLE)
        begin
            hold_cnt_r <= '0;
            hold_rd_r <= '0;
        end
        else
        begin
            if (push)
                hold_cnt_r <= hold_cnt_r + 1'b1;
            if (state_r == sscp_pkg::SSCP_ST_FLUSH)
                hold_rd_r <= hold_rd_r + 1'b1;
        end
    end

    // Buffer contents carry no reset; only counted entries are read
    always_ff @(posedge sys_clk_i)
    begin
        if (push)
            hold_r[hold_cnt_r] <= host_byte_i;
        if (rst_i)
            op_r <= 8'h00;
        else if (push && state_r == sscp_pkg::SSCP_ST_OPC)
            op_r <= host_byte_i;
    end

    // Data toward the slaves; an empty mask means nobody listens
    always_ff @(posedge sys_clk_i)
    begin
        if (rst_i)
        begin
            slv_valid_o <= 1'b0;
            slv_byte_o <= 8'h00;
            slv_mask_o <= 4'h0;
        end
        else
        begin
            slv_mask_o <= tx_mask_r;
            if (state_r == sscp_pkg::SSCP_ST_FLUSH)
            begin
                slv_valid_o <= (tx_mask_r != 4'h0);
                slv_byte_o <= hold_r[hold_rd_r];
            end
            else if (fwd)
            begin
                slv_valid_o <= (tx_mask_r != 4'h0);
                slv_byte_o <= host_byte_i;
            end
            else
                slv_valid_o <= 1'b0;
        end
    end

    // Connections; reset takes the strapped initial selections
    always_ff @(posedge sys_clk_i)
    begin
        if (rst_i)
        begin
            tx_mask_r <= cfg_init_tx_mask_i;
            rx_sel_o <= cfg_init_rx_sel_i;
        end
        else if (cmd_sel)
        begin
            tx_mask_r <= 4'h1 << sel_diff[1:0];
            rx_sel_o <= 4'h1 << sel_diff[1:0];
        end
        else if (cmd_off)
        begin
            tx_mask_r <= 4'h0;
            rx_sel_o <= 4'h0;
        end
        else if (cmd_send)
            tx_mask_r <= host_byte_i[sscp_pkg::SSCP_MASK_MSB:0];
    end

    // One-cycle requests to the slave buffers and the timer
    always_ff @(posedge sys_clk_i)
    begin
        if (rst_i)
        begin
            drain_o <= 1'b0;
            purge_o <= 4'h0;
            ign_start_r <= 1'b0;
            ign_code_r <= 4'h0;
        end
        else
        begin
            drain_o <= cmd_sel;
            purge_o <= cmd_clr ? host_byte_i[sscp_pkg::SSCP_MASK_MSB:0] : 4'h0;
            ign_start_r <= cmd_ign;
            ign_code_r <= host_byte_i[3:0];
        end
    end

    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (rst_i);

    a_prefix_held: assert property (state_r == sscp_pkg::SSCP_ST_IDLE && accept && detect && is_first
        |=> !slv_valid_o) else $error("prefix byte forwarded");
    a_select_port: assert property (state_r == sscp_pkg::SSCP_ST_OPC && accept && host_byte_i == 8'h42
        |=> rx_sel_o == 4'h2 && tx_mask_r == 4'h2 && drain_o ##1 !drain_o)
        else $error("select B wrong");
    a_off_clears: assert property (state_r == sscp_pkg::SSCP_ST_OPC && accept && is_off
        |=> rx_sel_o == 4'h0 && tx_mask_r == 4'h0 && !slv_valid_o) else $error("off failed");
    a_send_mask: assert property (state_r == sscp_pkg::SSCP_ST_PARM && accept && op_r == sscp_pkg::SSCP_OPC_SEND
        |=> tx_mask_r == $past(host_byte_i[3:0]) && $stable(rx_sel_o)) else $error("send mask wrong");
    a_purge_map: assert property (state_r == sscp_pkg::SSCP_ST_PARM && accept && op_r == sscp_pkg::SSCP_OPC_CLEAR
        |=> purge_o == $past(host_byte_i[3:0]) ##1 purge_o == 4'h0) else $error("purge wrong");
    a_pass_data: assert property (state_r == sscp_pkg::SSCP_ST_IDLE && accept && !detect && tx_mask_r != 4'h0
        |=> slv_valid_o && slv_byte_o == $past(host_byte_i)) else $error("window byte lost");
    a_flush_stall: assert property ($rose(state_r == sscp_pkg::SSCP_ST_FLUSH)
        |-> !host_ready_o ##1 slv_valid_o == (tx_mask_r != 4'h0) && slv_byte_o == hold_r[0])
        else $error("release wrong");
    // A non-digit ignore parameter is released as data, so only real digits start the window
    a_ign_start: assert property (state_r == sscp_pkg::SSCP_ST_PARM && accept && op_r == sscp_pkg::SSCP_OPC_IGNORE
        && is_digit && host_byte_i != sscp_pkg::SSCP_DIGIT_0 |-> ##2 ign_active_o)
        else $error("window not started");
    a_bad_opcode: assert property (state_r == sscp_pkg::SSCP_ST_OPC && accept && !is_sel && !is_off && !is_parm_op
        |=> state_r == sscp_pkg::SSCP_ST_FLUSH && $stable(rx_sel_o)) else $error("bad opcode kept");

    c_select: cover property (drain_o);
    c_release: cover property (state_r == sscp_pkg::SSCP_ST_FLUSH);
    c_window: cover property ($rose(ign_active_o));
    c_broadcast: cover property (slv_valid_o && slv_mask_o == 4'hF);
endmodule // sscp_parser

// [sscp_pkg.sv]
package sscp_pkg;
    // Port count and mask field of a parameter byte
    localparam int SSCP_PORTS = 4;
    localparam int SSCP_MASK_MSB = 3;

    // Power-up command prefix, three-byte form
    localparam logic [7:0] SSCP_DEF_FIRST = 8'h1B;
    localparam logic [7:0] SSCP_DEF_SECOND = 8'h02;
    localparam logic [7:0] SSCP_DEF_THIRD = 8'h30;
    localparam logic SSCP_DEF_FOUR_BYTE = 1'b0;

    // Operation codes and parameter digits
    localparam logic [7:0] SSCP_OPC_SEL_A = 8'h41;
    localparam logic [7:0] SSCP_OPC_SEL_D = 8'h44;
    localparam logic [7:0] SSCP_OPC_OFF = 8'h04;
    localparam logic [7:0] SSCP_OPC_SEND = 8'h53;
    localparam logic [7:0] SSCP_OPC_CLEAR = 8'h58;
    localparam logic [7:0] SSCP_OPC_IGNORE = 8'h54;
    localparam logic [7:0] SSCP_DIGIT_0 = 8'h30;
    localparam logic [7:0] SSCP_DIGIT_9 = 8'h39;

    // Holding buffer: up to three prefix bytes, opcode and parameter
    localparam int SSCP_HOLD_DEPTH = 5;
    localparam int SSCP_HOLD_W = 3;

    // Timing: 40 MHz clock, ignore window counted in milliseconds
    localparam int SSCP_CLK_HZ = 40000000;
    localparam int SSCP_MS_PER_S = 1000;
    localparam int SSCP_TICK_MS = 1;
    localparam int SSCP_CYC_PER_TICK = SSCP_CLK_HZ / SSCP_MS_PER_S * SSCP_TICK_MS;
    localparam int SSCP_PRE_W = 16;
    localparam int SSCP_MS_W = 19;
    // Window lengths in ms for digits 0..9; digit 0 stops the window
    localparam logic [18:0] SSCP_IGN_MS [0:9] = '{
        19'h00000, 19'h0000A, 19'h00019, 19'h00064, 19'h001F4,
        19'h003E8, 19'h01388, 19'h07530, 19'h0EA60, 19'h493E0
    };

    typedef enum logic [5:0] {
        SSCP_ST_IDLE  = 6'h01,
        SSCP_ST_P2    = 6'h02,
        SSCP_ST_P3    = 6'h04,
        SSCP_ST_OPC   = 6'h08,
        SSCP_ST_PARM  = 6'h10,
        SSCP_ST_FLUSH = 6'h20
    } sscp_state_t;
endpackage

// [sscp_sync2.sv]
`timescale 1ns/1ps
module sscp_sync2
(
    input wire logic sys_clk_i,
    input wire logic rst_i,
    input wire logic d_i,
    output logic q_o
);
    logic meta_r;

    // Two stages; only the second is read outside
    always_ff @(posedge sys_clk_i)
    begin
        if (rst_i)
        begin
            meta_r <= 1'b0;
            q_o <= 1'b0;
        end
        else
        begin
            meta_r <= d_i;
            q_o <= meta_r;
        end
    end
endmodule // sscp_sync2

// [sscp_ign_timer.sv]
`timescale 1ns/1ps
module sscp_ign_timer #(
    parameter int CYC_PER_MS = sscp_pkg::SSCP_CYC_PER_TICK
)
(
    input wire logic sys_clk_i,
    input wire logic rst_i,
    input wire logic start_i,
    input wire logic [3:0] code_i,
    output logic active_o
);
    logic [sscp_pkg::SSCP_PRE_W-1:0] pre_r;
    logic [sscp_pkg::SSCP_MS_W-1:0] ms_left_r;
    logic tick;

    assign tick = (pre_r == sscp_pkg::SSCP_PRE_W'(CYC_PER_MS - 1));

    // Millisecond prescaler, restarted with each window so the first ms is whole
    always_ff @(posedge sys_clk_i)
    begin
        if (rst_i || start_i || !active_o || tick)
            pre_r <= '0;
        else
            pre_r <= pre_r + 1'b1;
    end

    // Window: a new start replaces any running one; digit 0 stops it
    always_ff @(posedge sys_clk_i)
    begin
        if (rst_i)
        begin
            active_o <= 1'b0;
            ms_left_r <= '0;
        end
        else if (start_i)
        begin
            active_o <= (code_i != 4'h0);
            ms_left_r <= sscp_pkg::SSCP_IGN_MS[code_i] - 1'b1;
        end
        else if (active_o && tick)
        begin
            if (ms_left_r == '0)
                active_o <= 1'b0; // Detection resumes
            else
                ms_left_r <= ms_left_r - 1'b1;
        end
    end
endmodule // sscp_ign_timer

// [sscp_host_model.sv]
`timescale 1ns/1ps
// Host on the master port, offering one byte at a time
module sscp_host_model
(
    input wire logic sys_clk_i,
    input wire logic ready_i,
    output logic valid_o,
    output logic [7:0] byte_o
);
    initial
    begin
        valid_o = 1'b0;
        byte_o = 8'h00;
    end
    // Byte and valid held until ready is sampled high; bounded
    task automatic send(input logic [7:0] b, output logic ok);
        int n;
        n = 0;
        valid_o <= 1'b1;
        byte_o <= b;
        do
        begin
            @(posedge sys_clk_i);
            n++;
        end
        while (ready_i !== 1'b1 && n < 64);
        ok = (ready_i === 1'b1);
    endtask
    // Released line shows the inverse, never the stale byte
    task automatic idle();
        valid_o <= 1'b0;
        byte_o <= ~byte_o;
    endtask
endmodule // sscp_host_model

// [testbench.sv]
`timescale 1ns/1ps
module testbench;
    localparam int CPM = 4;
    logic sys_clk_i, rst_i, host_valid_i, host_dtr_i, cfg_load_i, cfg_four_byte_i, cfg_dtr_gate_i;
    logic host_ready_o, slv_valid_o, drain_o, ign_active_o;
    logic [7:0] host_byte_i, slv_byte_o, p1, p2, p3;
    logic [3:0] init_tx, init_rx, slv_mask_o, rx_sel_o, purge_o, purge_seen, exp_mask, m;
    logic [11:0] exp_q[$];
    logic [31:0] rng;
    int errors, checks, drains, ign_cnt, d0;
    int win_ms[6] = '{0, 10, 25, 100, 500, 1000};

    sscp_parser #(.CYC_PER_MS(CPM)) sscp_parser_inst (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
        .host_valid_i(host_valid_i), .host_byte_i(host_byte_i), .host_dtr_i(host_dtr_i),
        .cfg_load_i(cfg_load_i), .cfg_four_byte_i(cfg_four_byte_i), .cfg_prefix_first_i(p1),
        .cfg_prefix_second_i(p2), .cfg_prefix_third_i(p3), .cfg_dtr_gate_i(cfg_dtr_gate_i),
        .cfg_init_tx_mask_i(init_tx), .cfg_init_rx_sel_i(init_rx), .host_ready_o(host_ready_o),
        .slv_valid_o(slv_valid_o), .slv_byte_o(slv_byte_o), .slv_mask_o(slv_mask_o),
        .rx_sel_o(rx_sel_o), .drain_o(drain_o), .purge_o(purge_o), .ign_active_o(ign_active_o));
    sscp_host_model sscp_host_model_inst (.sys_clk_i(sys_clk_i), .ready_i(host_ready_o),
        .valid_o(host_valid_i), .byte_o(host_byte_i));

    initial
    begin
        sys_clk_i = 1'b0;
        forever #12.5 sys_clk_i = ~sys_clk_i;
    end

    task automatic complete_run();
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic chk(input string what, input logic [11:0] exp, input logic [11:0] got);
        checks++;
        if (got !== exp)
        begin
            errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Data bytes kept in 40..7F so they never alias the first prefix byte
    function automatic logic [7:0] rnd();
        rng = rng ^ (rng << 13);
        rng = rng ^ (rng >> 17);
        rng = rng ^ (rng << 5);
        return 8'h40 | {1'b0, rng[6:0]};
    endfunction

    // Note the expected slave byte before offering it
    task automatic put(input logic [7:0] b, input bit fwd);
        logic ok;
        if (fwd && exp_mask != 4'h0)
            exp_q.push_back({exp_mask, b});
        sscp_host_model_inst.send(b, ok);
        if (!ok)
        begin
            errors++;
            $display("[ERR] host handshake expected ready seen stall");
            complete_run();
        end
    endtask

    // Bytes go out most significant first, then the line is released
    task automatic seq(input logic [39:0] v, input int n, input bit fwd);
        for (int i = n - 1; i >= 0; i--)
            put(v[8*i +: 8], fwd);
        sscp_host_model_inst.idle();
        repeat (6) @(posedge sys_clk_i);
    endtask

    task automatic do_reset(input logic [3:0] tx, input logic [3:0] rx);
        init_tx <= tx;
        init_rx <= rx;
        rst_i <= 1'b1;
        repeat (4) @(posedge sys_clk_i);
        rst_i <= 1'b0;
        exp_mask = tx;
        repeat (3) @(posedge sys_clk_i);
    endtask

    task automatic load(input logic [7:0] a, input logic [7:0] b, input logic [7:0] c, input logic four,
        input logic gate);
        p1 <= a;
        p2 <= b;
        p3 <= c;
        cfg_four_byte_i <= four;
        cfg_dtr_gate_i <= gate;
        cfg_load_i <= 1'b1;
        @(posedge sys_clk_i);
        cfg_load_i <= 1'b0;
        @(posedge sys_clk_i);
    endtask

    // Watcher: every slave byte is matched against the oldest note
    always @(posedge sys_clk_i)
    begin
        if (!rst_i)
        begin
            if (slv_valid_o === 1'b1 && exp_q.size() == 0)
            begin
                checks++;
                errors++;
                $display("[ERR] slave byte expected none seen %h", slv_byte_o);
            end
            else if (slv_valid_o === 1'b1)
                chk("slave byte", exp_q.pop_front(), {slv_mask_o, slv_byte_o});
            if (drain_o === 1'b1)
                drains++;
            if (ign_active_o === 1'b1)
                ign_cnt++;
            purge_seen = purge_seen | purge_o;
        end
    end

    initial
    begin
        rng = 32'h0000710F;
        errors = 0;
        checks = 0;
        drains = 0;
        ign_cnt = 0;
        purge_seen = 4'h0;
        exp_mask = 4'h0;
        rst_i = 1'b1;
        host_dtr_i = 1'b1;
        cfg_load_i = 1'b0;
        cfg_four_byte_i = 1'b0;
        cfg_dtr_gate_i = 1'b0;
        p1 = 8'h1B;
        p2 = 8'h02;
        p3 = 8'h30;
        init_tx = 4'h0;
        init_rx = 4'h0;
        do_reset(4'h0, 4'h0);
        chk("idle mask", 12'h000, {4'h0, slv_mask_o, rx_sel_o});
        seq({32'h0, rnd()}, 1, 1'b1);
        $display("test no_initial_connection done");
        for (int p = 0; p < 4; p++)
        begin
            m = 4'h1 << p;
            d0 = drains;
            seq({16'h0, 24'h1B0241 + 24'(p)}, 3, 1'b0);
            chk("select", {4'h0, m, m}, {4'h0, slv_mask_o, rx_sel_o});
            chk("drain pulses", 12'h001, 12'(drains - d0));
            exp_mask = m;
            seq({32'h0, rnd()}, 1, 1'b1);
        end
        $display("test port_select done");
        seq({24'h0, 16'h1B41}, 2, 1'b1);
        seq({8'h0, rnd(), 24'h1B025A}, 4, 1'b1);
        chk("select kept", 12'h008, {8'h0, rx_sel_o});
        $display("test released_bytes done");
        // Odd masks sent with 64 added, upper nibble must not matter
        for (int v = 0; v < 16; v++)
        begin
            seq({8'h0, 24'h1B0253, 8'(v) | (v[0] ? 8'h40 : 8'h00)}, 4, 1'b0);
            chk("send mask", {4'h0, 4'(v), 4'h8}, {4'h0, slv_mask_o, rx_sel_o});
        end
        seq({8'h0, 32'h1B025346}, 4, 1'b0);
        exp_mask = 4'h6;
        seq({32'h0, rnd()}, 1, 1'b1);
        purge_seen = 4'h0;
        seq({8'h0, 32'h1B025849}, 4, 1'b0);
        chk("purge", 12'h069, {4'h0, slv_mask_o, purge_seen});
        $display("test send_and_purge done");
        seq({16'h0, 24'h1B0204}, 3, 1'b0);
        chk("all off", 12'h000, {4'h0, slv_mask_o, rx_sel_o});
        exp_mask = 4'h0;
        seq({32'h0, rnd()}, 1, 1'b1);
        $display("test deselect done");
        seq({16'h0, 24'h1B0241}, 3, 1'b0);
        exp_mask = 4'h1;
        for (int d = 0; d < 6; d++)
        begin
            ign_cnt = 0;
            seq({8'h0, 24'h1B0254, 8'h30 + 8'(d)}, 4, 1'b0);
            if (d == 1)
                seq({16'h0, 24'h1B0242}, 3, 1'b1);
            for (int n = 0; n < 5000 && ign_active_o !== 1'b0; n++)
                @(posedge sys_clk_i);
            if (ign_active_o !== 1'b0)
            begin
                errors++;
                $display("[ERR] ignore window expected end seen active");
                complete_run();
            end
            d0 = win_ms[d] * CPM;
            chk("ignore window", 12'(d0), 12'((ign_cnt == d0 + 1) ? d0 : ign_cnt));
            chk("select during window", 12'h001, {8'h0, rx_sel_o});
        end
        $display("test ignore_window done");
        load(8'hA5, 8'h5A, 8'h3C, 1'b1, 1'b0);
        seq({16'h0, 24'hA55A43}, 3, 1'b1);
        seq({8'h0, 32'hA55A3C43}, 4, 1'b0);
        chk("four byte select", 12'h044, {4'h0, slv_mask_o, rx_sel_o});
        exp_mask = 4'h4;
        $display("test four_byte done");
        load(8'h1B, 8'h02, 8'h30, 1'b0, 1'b1);
        host_dtr_i <= 1'b0;
        repeat (4) @(posedge sys_clk_i);
        seq({16'h0, 24'h1B0241}, 3, 1'b1);
        chk("gated select", 12'h004, {8'h0, rx_sel_o});
        host_dtr_i <= 1'b1;
        repeat (4) @(posedge sys_clk_i);
        seq({16'h0, 24'h1B0241}, 3, 1'b0);
        chk("dtr select", 12'h001, {8'h0, rx_sel_o});
        $display("test dtr_gate done");
        do_reset(4'h5, 4'h2);
        chk("initial state", 12'h052, {4'h0, slv_mask_o, rx_sel_o});
        seq({32'h0, rnd()}, 1, 1'b1);
        seq({16'h0, 24'h1B0244}, 3, 1'b0);
        chk("default prefix", 12'h008, {8'h0, rx_sel_o});
        $display("test initial_connection done");
        chk("pending bytes", 12'h000, 12'(exp_q.size()));
        complete_run();
    end
endmodule // testbench
